// ### core/phase_shed_regs.sv
// phase-shedding configuration registers behind the two-wire management port
//
// Summary of operation
// R1 - The level-three threshold is an 8-bit read/write field resetting to 0x40, 12.5 mV a count.
// R2 - With pin strapping enabled the level-three default comes from phase output five's strap.
// R3 - The level-four threshold is an 8-bit read/write field resetting to 0x60, 12.5 mV a count.
// R4 - With pin strapping enabled the level-four default comes from phase output seven's strap.
// R5 - Margin one is 3 bits resetting to 4 and sets level one's rise and fall points.
// R6 - Margin two is 3 bits resetting to 4 and sets level two's rise and fall points.
// R7 - Margin three is 3 bits resetting to 4 and sets level three's rise and fall points.
// R8 - Margin four is 3 bits resetting to 4 and sets level four's rise and fall points.
// R9 - The state-four phase count is 3 bits resetting to 7, a value n meaning n plus one phases.
// R10 - The state-three phase count is 3 bits resetting to 5, six phases.
// R11 - The state-two phase count is 3 bits resetting to 3, four phases.
// R12 - Writes land only while the lock differs from 0xA6 and the state indicator or override is high.
// R13 - The lock value 0xA6 locks this range and any other value unlocks it.
// R14 - Bus data is taken only while power good is high and refused with a not-acknowledge otherwise; a refused register byte still loads the pointer.
// R15 - A refused write leaves the field unchanged and reads still return the stored value.
// R16 - The load state rises above a level's upper point, falls below its lower point, and drives the phase count.
`timescale 1ns/10ps
module phase_shed_regs
  import phase_shed_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDR = 7'h2A  // arbitrary bus address
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       powerGood,
  input  wire logic       powerStateIndicator,
  input  wire logic       overrideBit,
  input  wire logic [7:0] lockValue,
  input  wire logic       pinStrapSetting,
  input  wire logic [7:0] strapPhaseOutputFive,
  input  wire logic [7:0] strapPhaseOutputSeven,
  input  wire logic [7:0] loadLevelOne,
  input  wire logic [7:0] loadLevelTwo,
  input  wire logic [2:0] loadStateOnePhases,
  input  wire logic [2:0] loadStateZeroPhases,
  input  wire logic [7:0] loadMonitor,
  output logic      [2:0] loadState,
  output logic      [2:0] phaseCount
);
  function automatic logic regHit(input logic [7:0] ptr, input logic [7:0] off);
    return ptr == off;
  endfunction

  // pins are asynchronous to clock; bus lines rest high, power good and indicator start low
  logic [3:0] pinSync;
  sync_two_flop #(.WIDTH(4), .RESET_VAL(4'h3)) pinSyncer (
    .clock   (clock),
    .rstn    (rstn),
    .asyncIn ({powerStateIndicator, powerGood, sdaIn, sclIn}),
    .syncOut (pinSync)
  );
  wire scl     = pinSync[0];
  wire sda     = pinSync[1];
  wire power_good   = pinSync[2];
  wire psiHigh = pinSync[3];

  logic       sclPrev;
  logic       sdaPrev;
  bus_state_e state;
  logic [7:0] shifter;
  logic [3:0] bitCnt;
  logic [7:0] pointer;
  logic       isRead;
  logic       masterNak;

  // configuration fields
  logic [7:0] loadLevelThree;
  logic [7:0] loadLevelFour;
  logic [2:0] levelMargin [NUM_MARGINS];
  logic [2:0] loadStateFour;
  logic [2:0] loadStateThree;
  logic [2:0] loadStateTwo;
  logic       strapDone;

  wire sclRise   = scl && !sclPrev;
  wire sclFall   = !scl && sclPrev;
  wire startCond = scl && sclPrev && sdaPrev && !sda;
  wire stopCond  = scl && sclPrev && !sdaPrev && sda;
  wire byteDone  = bitCnt == BITS_PER_BYTE;
  wire addrMatch = shifter[7:1] == DEVICE_ADDR;

  wire wrStrobe     = sclFall && (state == BUS_WDATA) && byteDone && power_good; // R14
  wire locked       = lockValue == LOCK_CODE;                                // R13
  wire writeAllowed = !locked && (psiHigh || overrideBit);                   // R12
  wire fieldWrite   = wrStrobe && writeAllowed;                              // R15

  wire [7:0] readData =
      regHit(pointer, OFF_LEVEL_THREE)        ? loadLevelThree :
      regHit(pointer, OFF_LEVEL_FOUR)         ? loadLevelFour :
      regHit(pointer, OFF_MARGIN_ONE)         ? {5'h00, levelMargin[0]} :
      regHit(pointer, OFF_MARGIN_ONE + 8'h01) ? {5'h00, levelMargin[1]} :
      regHit(pointer, OFF_MARGIN_ONE + 8'h02) ? {5'h00, levelMargin[2]} :
      regHit(pointer, OFF_MARGIN_ONE + 8'h03) ? {5'h00, levelMargin[3]} :
      regHit(pointer, OFF_STATE_FOUR)         ? {5'h00, loadStateFour} :
      regHit(pointer, OFF_STATE_THREE)        ? {5'h00, loadStateThree} :
      regHit(pointer, OFF_STATE_TWO)          ? {5'h00, loadStateTwo} : 8'h00; // R15

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= scl;
      sdaPrev <= sda;
    end
  end

  // the port only ever pulls low, so the driven level is a constant zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state     <= BUS_IDLE;
      shifter   <= 8'h00;
      bitCnt    <= 4'h0;
      pointer   <= 8'h00;
      isRead    <= 1'b0;
      masterNak <= 1'b0;
      sdaOe     <= 1'b0;
    end else if (startCond) begin
      state  <= BUS_ADDR;
      bitCnt <= 4'h0;
      sdaOe  <= 1'b0;
    end else if (stopCond) begin
      state <= BUS_IDLE;
      sdaOe <= 1'b0;
    end else if (sclRise) begin
      unique case (state)
        BUS_ADDR, BUS_REG, BUS_WDATA: begin
          shifter <= {shifter[6:0], sda};
          bitCnt  <= 4'(bitCnt + 4'h1);
        end
        BUS_RDATA_ACK: masterNak <= sda;
        default: ;
      endcase
    end else if (sclFall) begin
      unique case (state)
        BUS_IDLE: ;
        BUS_ADDR: begin
          if (byteDone && addrMatch && power_good) begin // R14
            state  <= BUS_ADDR_ACK;
            sdaOe  <= 1'b1;
            isRead <= shifter[0];
          end else if (byteDone) begin
            state <= BUS_IDLE;
          end
        end
        BUS_ADDR_ACK: begin
          if (isRead) begin
            state   <= BUS_RDATA;
            shifter <= readData;
            sdaOe   <= !readData[7];
            bitCnt  <= 4'h1;
            pointer <= 8'(pointer + 8'h01);
          end else begin
            state  <= BUS_REG;
            sdaOe  <= 1'b0;
            bitCnt <= 4'h0;
          end
        end
        BUS_REG: begin
          if (byteDone) begin
            pointer <= shifter;
            sdaOe   <= power_good; // R14
            state   <= power_good ? BUS_REG_ACK : BUS_IDLE;
          end
        end
        BUS_REG_ACK, BUS_WDATA_ACK: begin
          state  <= BUS_WDATA;
          sdaOe  <= 1'b0;
          bitCnt <= 4'h0;
        end
        BUS_WDATA: begin
          if (byteDone) begin
            // a write refused by the lock is still acknowledged; the field just keeps its value
            pointer <= power_good ? 8'(pointer + 8'h01) : pointer;
            sdaOe   <= power_good; // R14
            state   <= power_good ? BUS_WDATA_ACK : BUS_IDLE;
          end
        end
        BUS_RDATA: begin
          if (byteDone) begin
            state <= BUS_RDATA_ACK;
            sdaOe <= 1'b0;
          end else begin
            sdaOe   <= !shifter[6];
            shifter <= {shifter[6:0], 1'b0};
            bitCnt  <= 4'(bitCnt + 4'h1);
          end
        end
        BUS_RDATA_ACK: begin
          if (masterNak) begin
            state <= BUS_IDLE;
          end else begin
            state   <= BUS_RDATA;
            shifter <= readData;
            sdaOe   <= !readData[7];
            bitCnt  <= 4'h1;
            pointer <= 8'(pointer + 8'h01);
          end
        end
        default: state <= BUS_IDLE;
      endcase
    end
  end

  // straps are sampled once, on the first edge after reset release
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strapDone <= 1'b0;
    end else begin
      strapDone <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      loadLevelThree <= RST_LEVEL_THREE; // R1
      loadLevelFour  <= RST_LEVEL_FOUR;  // R3
    end else if (!strapDone) begin
      loadLevelThree <= pinStrapSetting ? strapPhaseOutputFive : RST_LEVEL_THREE;  // R2
      loadLevelFour  <= pinStrapSetting ? strapPhaseOutputSeven : RST_LEVEL_FOUR;  // R4
    end else if (fieldWrite) begin
      if (regHit(pointer, OFF_LEVEL_THREE)) loadLevelThree <= shifter; // R1
      if (regHit(pointer, OFF_LEVEL_FOUR)) loadLevelFour <= shifter;   // R3
    end
  end

  // margins one to four sit at consecutive offsets
  for (genvar i = 0; i < NUM_MARGINS; i++) begin : g_margin
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        levelMargin[i] <= RST_MARGIN; // R5 R6 R7 R8
      end else if (fieldWrite && regHit(pointer, OFF_MARGIN_ONE + 8'(i))) begin
        levelMargin[i] <= shifter[2:0]; // R5 R6 R7 R8
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      loadStateFour  <= RST_STATE_FOUR;  // R9
      loadStateThree <= RST_STATE_THREE; // R10
      loadStateTwo   <= RST_STATE_TWO;   // R11
    end else if (fieldWrite) begin
      if (regHit(pointer, OFF_STATE_FOUR)) loadStateFour <= shifter[2:0];   // R9
      if (regHit(pointer, OFF_STATE_THREE)) loadStateThree <= shifter[2:0]; // R10
      if (regHit(pointer, OFF_STATE_TWO)) loadStateTwo <= shifter[2:0];     // R11
    end
  end

  load_state_tracker #(.LEVELS(NUM_MARGINS)) tracker (
    .clock      (clock),
    .rstn       (rstn),
    .loadLevel  (loadMonitor),
    .levels     ({loadLevelFour, loadLevelThree, loadLevelTwo, loadLevelOne}),
    .margins    ({levelMargin[3], levelMargin[2], levelMargin[1], levelMargin[0]}),
    .phases     ({loadStateFour, loadStateThree, loadStateTwo, loadStateOnePhases,
                  loadStateZeroPhases}),
    .loadState  (loadState),
    .phaseCount (phaseCount)
  );

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  wire [36:0] allFields = {loadLevelThree, loadLevelFour, levelMargin[0], levelMargin[1],
                           levelMargin[2], levelMargin[3], loadStateFour, loadStateThree,
                           loadStateTwo};

  sequence addrByteEnds;
    sclFall && (state == BUS_ADDR) && byteDone;
  endsequence

  sequence busReleased;
    !sdaOe && (state == BUS_IDLE);
  endsequence

  chk_level_three_strap: assert property ( // R2
    !strapDone |=> loadLevelThree == ($past(pinStrapSetting) ? $past(strapPhaseOutputFive)
                                                              : RST_LEVEL_THREE))
    else $error("level three default not taken from strap or reset value");

  chk_level_four_strap: assert property ( // R4
    !strapDone |=> loadLevelFour == ($past(pinStrapSetting) ? $past(strapPhaseOutputSeven)
                                                             : RST_LEVEL_FOUR))
    else $error("level four default not taken from strap or reset value");

  chk_locked_write_held: assert property ( // R13
    wrStrobe && locked |=> $stable(allFields))
    else $error("field changed while the lock code was set");

  chk_psi_gate_holds: assert property ( // R12
    wrStrobe && !psiHigh && !overrideBit |=> $stable(allFields))
    else $error("field changed without state indicator or override");

  chk_level_three_write: assert property ( // R1
    fieldWrite && strapDone && regHit(pointer, OFF_LEVEL_THREE)
      |=> loadLevelThree == $past(shifter))
    else $error("allowed write to level three threshold lost");

  chk_level_four_write: assert property ( // R3
    fieldWrite && strapDone && regHit(pointer, OFF_LEVEL_FOUR)
      |=> loadLevelFour == $past(shifter))
    else $error("allowed write to level four threshold lost");

  chk_margin_one_write: assert property ( // R5
    fieldWrite && regHit(pointer, OFF_MARGIN_ONE) |=> levelMargin[0] == $past(shifter[2:0]))
    else $error("allowed write to margin one lost");

  chk_nak_no_power: assert property ( // R14
    addrByteEnds and !power_good |=> busReleased)
    else $error("address acknowledged while power good low");

  chk_read_returns_field: assert property ( // R15
    sclFall && (state == BUS_ADDR_ACK) && isRead && regHit(pointer, OFF_STATE_FOUR)
      |=> shifter == {5'h00, $past(loadStateFour)} ##0 state == BUS_RDATA)
    else $error("read did not return the stored phase count");

  chk_phase_four_drive: assert property ( // R9
    loadState == 3'h4 && $stable(loadStateFour) && $past(loadState) == 3'h4
      |-> phaseCount == loadStateFour)
    else $error("top load state does not drive its phase count");

  chk_rise_from_idle: assert property ( // R16
    loadState == 3'h0 && ({1'b0, loadMonitor} > ({1'b0, loadLevelOne} + {6'h00, levelMargin[0]}))
      |=> loadState == 3'h1 ##1 loadState inside {3'h0, 3'h1, 3'h2})
    else $error("load state did not rise above level one upper point");
endmodule // phase_shed_regs

// ### core/phase_shed_pkg.sv
// shared offsets, reset values, codes and states of the phase-shedding register bank
package phase_shed_pkg;
  // register offsets on the management bus
  localparam logic [7:0] OFF_LEVEL_THREE  = 8'h03;
  localparam logic [7:0] OFF_LEVEL_FOUR   = 8'h04;
  localparam logic [7:0] OFF_MARGIN_ONE   = 8'h05;
  localparam logic [7:0] OFF_STATE_FOUR   = 8'h09;
  localparam logic [7:0] OFF_STATE_THREE  = 8'h0A;
  localparam logic [7:0] OFF_STATE_TWO    = 8'h0B;
  // values after reset
  localparam logic [7:0] RST_LEVEL_THREE  = 8'h40;
  localparam logic [7:0] RST_LEVEL_FOUR   = 8'h60;
  localparam logic [2:0] RST_MARGIN       = 3'h4;
  localparam logic [2:0] RST_STATE_FOUR   = 3'h7;
  localparam logic [2:0] RST_STATE_THREE  = 3'h5;
  localparam logic [2:0] RST_STATE_TWO    = 3'h3;
  localparam logic [2:0] RST_LOAD_STATE   = 3'h0;
  localparam logic [2:0] RST_PHASE_COUNT  = 3'h0;
  // lock code that freezes the configuration range
  localparam logic [7:0] LOCK_CODE        = 8'hA6;
  // one count of any threshold or margin field, in microvolts (12.5 mV)
  localparam int         STEP_MICROVOLT   = 12500;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
  localparam int         NUM_MARGINS      = 4;

  typedef enum logic [3:0] {
    BUS_IDLE      = 4'b0000,
    BUS_ADDR      = 4'b0001,
    BUS_ADDR_ACK  = 4'b0010,
    BUS_REG       = 4'b0011,
    BUS_REG_ACK   = 4'b0100,
    BUS_WDATA     = 4'b0101,
    BUS_WDATA_ACK = 4'b0110,
    BUS_RDATA     = 4'b0111,
    BUS_RDATA_ACK = 4'b1000
  } bus_state_e;
endpackage

// ### core/sync_two_flop.sv
// two-flop synchroniser for a group of independent asynchronous levels
`timescale 1ns/10ps
module sync_two_flop #(
  parameter int               WIDTH     = 4,
  // idle level of each input, so that the release of reset shows no false edge
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] firstStage;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      firstStage <= RESET_VAL;
      syncOut    <= RESET_VAL;
    end else begin
      firstStage <= asyncIn;
      syncOut    <= firstStage;
    end
  end
endmodule // sync_two_flop

// ### core/load_state_tracker.sv
// steps the active load state up and down through the hysteresis windows
`timescale 1ns/10ps
module load_state_tracker
  import phase_shed_pkg::*;
#(
  parameter int LEVELS = 4
) (
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic [7:0]          loadLevel,
  input  wire logic [8*LEVELS-1:0] levels,
  input  wire logic [3*LEVELS-1:0] margins,
  input  wire logic [3*LEVELS+2:0] phases,
  output logic      [2:0]          loadState,
  output logic      [2:0]          phaseCount
);
  logic [2:0] next_loadState;
  wire  [1:0] upIdx    = loadState[1:0];
  wire  [1:0] downIdx  = 2'(loadState - 3'h1);
  wire  [7:0] upLevel  = levels[8*upIdx +: 8];
  wire  [2:0] upMargin = margins[3*upIdx +: 3];
  wire  [7:0] dnLevel  = levels[8*downIdx +: 8];
  wire  [2:0] dnMargin = margins[3*downIdx +: 3];
  // compare with load plus margin on the low side so the low point never wraps below zero
  wire riseHit = (loadState != 3'(LEVELS))
               && ({1'b0, loadLevel} > ({1'b0, upLevel} + {6'h00, upMargin}));
  wire fallHit = (loadState != 3'h0)
               && (({1'b0, loadLevel} + {6'h00, dnMargin}) < {1'b0, dnLevel});

  assign next_loadState = riseHit ? 3'(loadState + 3'h1)
                        : fallHit ? 3'(loadState - 3'h1) : loadState; // R16

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      loadState  <= RST_LOAD_STATE;
      phaseCount <= RST_PHASE_COUNT;
    end else begin
      loadState  <= next_loadState;
      phaseCount <= phases[3*next_loadState +: 3]; // R16
    end
  end
endmodule // load_state_tracker

// ### tb/i2c_host_model.sv
// board-side two-wire bus host that reaches the register bank
`timescale 1ns/10ps
module i2c_host_model #(
  parameter logic [6:0] DEVICE_ADDR = 7'h2A  // arbitrary bus address
) (
  input  wire logic clock,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaLow
);
  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // data moves only while the bus clock is low; 8-cycle phases leave margin over the synchroniser
  task automatic clk_bit(input logic b, output logic r);
    sdaLow = ~b;
    wait_cyc(8);
    scl = 1'b1;
    wait_cyc(8);
    r   = sdaLine;
    scl = 1'b0;
    wait_cyc(4);
  endtask

  // also serves as repeated start, so it begins with the data line released
  task automatic start_cond();
    sdaLow = 1'b0;
    wait_cyc(4);
    scl = 1'b1;
    wait_cyc(8);
    sdaLow = 1'b1;
    wait_cyc(8);
    scl = 1'b0;
    wait_cyc(4);
  endtask

  task automatic stop_cond();
    sdaLow = 1'b1;
    wait_cyc(4);
    scl = 1'b1;
    wait_cyc(8);
    sdaLow = 1'b0;
    wait_cyc(8);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(~more, r);
  endtask

  task automatic wr(input logic [7:0] off, input logic [7:0] data, output logic [2:0] acks);
    start_cond();
    send_byte({DEVICE_ADDR, 1'b0}, acks[2]);
    send_byte(off, acks[1]);
    send_byte(data, acks[0]);
    stop_cond();
  endtask

  task automatic rd(input logic [7:0] off, output logic [7:0] data);
    logic a;
    start_cond();
    send_byte({DEVICE_ADDR, 1'b0}, a);
    send_byte(off, a);
    start_cond();
    send_byte({DEVICE_ADDR, 1'b1}, a);
    recv_byte(1'b0, data);
    stop_cond();
  endtask
endmodule // i2c_host_model

// ### tb/testbench.sv
// self-checking bench for the phase-shedding register bank
`timescale 1ns/10ps
module testbench
  import phase_shed_pkg::*;
;
  typedef struct {logic [7:0] off; logic [7:0] rstVal; logic [7:0] wrVal;} row_s;
  logic        clock, rstn, sclPin, hostLow, sdaOut, sdaOe, sdaLine;
  logic        powerGood, powerStateIndicator, overrideBit, pinStrapSetting;
  logic [7:0]  lockValue, strapFive, strapSeven, levelOne, levelTwo, loadMonitor;
  logic [7:0]  rdData, expVal;
  logic [2:0]  phasesOne, phasesZero, loadState, phaseCount, acks;
  logic [10:0] gates [4];
  row_s        rows [9];
  int          bad_count, n_compared;

  // pulled-up data wire: low whenever either party pulls it
  assign sdaLine = ~(hostLow | (sdaOe & ~sdaOut));

  phase_shed_regs uut (
    .clock(clock), .rstn(rstn), .sclIn(sclPin), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .powerGood(powerGood), .powerStateIndicator(powerStateIndicator),
    .overrideBit(overrideBit), .lockValue(lockValue), .pinStrapSetting(pinStrapSetting),
    .strapPhaseOutputFive(strapFive), .strapPhaseOutputSeven(strapSeven),
    .loadLevelOne(levelOne), .loadLevelTwo(levelTwo), .loadStateOnePhases(phasesOne),
    .loadStateZeroPhases(phasesZero), .loadMonitor(loadMonitor), .loadState(loadState),
    .phaseCount(phaseCount)
  );

  i2c_host_model host (.clock(clock), .sdaLine(sdaLine), .scl(sclPin), .sdaLow(hostLow));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_code(input string what, input logic [2:0] exp, input logic [2:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset(input logic strap);
    rstn            = 1'b0;
    pinStrapSetting = strap;
    cyc(2);
    rstn = 1'b1;
    cyc(6);
  endtask

  // the tracker moves one state per clock, so 20 cycles is ample for any walk
  task automatic settle(input logic [2:0] target);
    int n;
    n = 0;
    while (loadState !== target && n < 20) begin
      cyc(1);
      n++;
    end
    if (loadState !== target) begin
      bad_count++;
      $display("Error loadState expected %h seen %h", target, loadState);
      complete_run();
    end
    cyc(3);
  endtask

  initial begin
    rows = '{'{8'h03, 8'h40, 8'h5A}, '{8'h04, 8'h60, 8'hA5}, '{8'h05, 8'h04, 8'h01},
             '{8'h06, 8'h04, 8'h02}, '{8'h07, 8'h04, 8'h07}, '{8'h08, 8'h04, 8'h00},
             '{8'h09, 8'h07, 8'h00}, '{8'h0A, 8'h05, 8'h06}, '{8'h0B, 8'h03, 8'h01}};
    // lock, indicator, override, write expected to land
    gates = '{{8'hA6, 1'b1, 1'b1, 1'b0}, {8'h00, 1'b0, 1'b0, 1'b0},
              {8'h00, 1'b0, 1'b1, 1'b1}, {8'hA5, 1'b1, 1'b0, 1'b1}};
    bad_count = 0;
    n_compared = 0;
    powerGood = 1'b1;
    powerStateIndicator = 1'b1;
    overrideBit = 1'b0;
    lockValue = 8'h00;
    strapFive = 8'h9C;
    strapSeven = 8'h2E;
    levelOne = 8'h10;
    levelTwo = 8'h20;
    phasesOne = 3'h1;
    phasesZero = 3'h2;
    loadMonitor = 8'h00;
    do_reset(1'b0);

    loadMonitor = 8'h14;
    cyc(10);
    chk_code("state at rise point", 3'h0, loadState);
    loadMonitor = 8'h15;
    settle(3'h1);
    chk_code("phases state one", 3'h1, phaseCount);
    loadMonitor = 8'hFF;
    settle(3'h4);
    chk_code("phases state four", 3'h7, phaseCount);
    loadMonitor = 8'h5C;
    cyc(10);
    chk_code("state at fall point", 3'h4, loadState);
    loadMonitor = 8'h5B;
    settle(3'h3);
    chk_code("phases state three", 3'h5, phaseCount);
    loadMonitor = 8'h3B;
    settle(3'h2);
    chk_code("phases state two", 3'h3, phaseCount);
    loadMonitor = 8'h00;
    settle(3'h0);
    chk_code("phases state zero", 3'h2, phaseCount);
    $display("test load tracker done");

    foreach (rows[i]) begin
      host.rd(rows[i].off, rdData);
      chk_byte($sformatf("reset of %h", rows[i].off), rows[i].rstVal, rdData);
      host.wr(rows[i].off, rows[i].wrVal, acks);
      chk_code("write acks", 3'h7, acks);
      host.rd(rows[i].off, rdData);
      chk_byte($sformatf("readback of %h", rows[i].off), rows[i].wrVal, rdData);
    end
    $display("test register table done");

    expVal = 8'hA5;
    for (int i = 0; i < 4; i++) begin
      {lockValue, powerStateIndicator, overrideBit} = gates[i][10:1];
      cyc(5);
      host.wr(OFF_LEVEL_FOUR, 8'h30 + i[7:0], acks);
      if (gates[i][0]) expVal = 8'h30 + i[7:0];
      chk_code("gated acks", 3'h7, acks);
      host.rd(OFF_LEVEL_FOUR, rdData);
      chk_byte("gated write", expVal, rdData);
    end
    lockValue = 8'h00;
    powerStateIndicator = 1'b1;
    overrideBit = 1'b0;
    $display("test write gating done");

    powerGood = 1'b0;
    cyc(5);
    host.wr(OFF_LEVEL_THREE, 8'h77, acks);
    chk_code("acks without power good", 3'h0, acks);
    powerGood = 1'b1;
    cyc(5);
    host.rd(OFF_LEVEL_THREE, rdData);
    chk_byte("level three after refusal", 8'h5A, rdData);
    host.rd(8'h0E, rdData);
    chk_byte("unmapped offset", 8'h00, rdData);
    $display("test power good done");

    loadMonitor = 8'hFF;
    cyc(10);
    rstn = 1'b0;
    cyc(1);
    chk_code("state in reset", 3'h0, loadState);
    do_reset(1'b1);
    loadMonitor = 8'h00;
    host.rd(OFF_LEVEL_THREE, rdData);
    chk_byte("strapped level three", 8'h9C, rdData);
    host.rd(OFF_LEVEL_FOUR, rdData);
    chk_byte("strapped level four", 8'h2E, rdData);
    host.rd(OFF_MARGIN_ONE, rdData);
    chk_byte("margin one after strap", 8'h04, rdData);
    $display("test pin strap done");
    complete_run();
  end
endmodule // testbench
